// [design/xmu_pkg.sv]
// Functional notes
// - rotate right, bit0 into bit7, flags kept
// - rotate to-work variants leave memory unchanged
// - through-carry rotate: bit0 to carry, carry to bit7
// - borrow subtract: work minus mem minus inverted carry
// - plain subtract ignores carry, work or memory
// - carry clear if negative, else set
// - subtract updates wrap, zero, half, carry, signed, chained
// - decrement memory, store, skip on zero
// - increment memory, store, skip on zero
// - to-work inc/dec: work only, skip on zero
// - taken skip adds dummy cycle, three total
// - byte zero/nonzero test rewrites byte unchanged
// - copy byte to work, skip if zero
// - bit tests skip on selected bit value
// - fill operation writes all ones, no flags
// - bit set touches only selected bit
// - nibble exchange in place, no flags
// - to-work nibble exchange keeps memory unchanged
package xmu_pkg;
  localparam logic [11:0] XMU_CMD_OFS = 12'h000;
  localparam logic [11:0] XMU_WORK_OFS = 12'h004;
  localparam logic [11:0] XMU_FLAG_OFS = 12'h008;
  localparam logic [11:0] XMU_STAT_OFS = 12'h00c;
  localparam logic [1:0] XMU_MEM_SEL = 2'h1;
  localparam int XMU_OP_LSB = 0;
  localparam int XMU_BIT_LSB = 5;
  localparam int XMU_ADR_LSB = 8;
  localparam int XMU_FC = 0;
  localparam int XMU_FAC = 1;
  localparam int XMU_FZ = 2;
  localparam int XMU_FOV = 3;
  localparam int XMU_FSC = 4;
  localparam int XMU_FCZ = 5;
  localparam logic [7:0] XMU_WORK_RST = 8'h00;
  localparam logic [5:0] XMU_FLAG_RST = 6'h00;
  localparam logic [7:0] XMU_ONES = 8'hff;
  localparam logic [1:0] XMU_OKAY = 2'h0;
  localparam logic [1:0] XMU_SLVERR = 2'h2;
  localparam logic [4:0] OP_ROT = 5'h00;
  localparam logic [4:0] OP_ROT_W = 5'h01;
  localparam logic [4:0] OP_ROTC = 5'h02;
  localparam logic [4:0] OP_ROTC_W = 5'h03;
  localparam logic [4:0] OP_SBC_W = 5'h04;
  localparam logic [4:0] OP_SBC_M = 5'h05;
  localparam logic [4:0] OP_SUB_W = 5'h06;
  localparam logic [4:0] OP_SUB_M = 5'h07;
  localparam logic [4:0] OP_DSZ = 5'h08;
  localparam logic [4:0] OP_DSZ_W = 5'h09;
  localparam logic [4:0] OP_ISZ = 5'h0a;
  localparam logic [4:0] OP_ISZ_W = 5'h0b;
  localparam logic [4:0] OP_FILL = 5'h0c;
  localparam logic [4:0] OP_SETB = 5'h0d;
  localparam logic [4:0] OP_SZ = 5'h0e;
  localparam logic [4:0] OP_SNZ = 5'h0f;
  localparam logic [4:0] OP_SZ_W = 5'h10;
  localparam logic [4:0] OP_SZB = 5'h11;
  localparam logic [4:0] OP_SNZB = 5'h12;
  localparam logic [4:0] OP_SWAP = 5'h13;
  localparam logic [4:0] OP_SWAP_W = 5'h14;
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_COMMIT, ST_DUMMY} xmu_state_t;
endpackage

// [design/xmu_exec_unit.sv]
// extended memory-operand execute unit with axi4-lite register slave
//
// Our own choices: register access over AXI4-Lite and the register offsets.
module xmu_exec_unit (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic busy_o,
  output logic skip_o
);
  import xmu_pkg::*;

  xmu_state_t state_reg;
  logic [7:0] mem_reg [256];
  logic [7:0] work_reg;
  logic [5:0] flag_reg;
  logic [15:0] cmd_reg;
  logic [7:0] opnd_reg;
  logic skip_arm_reg;
  logic aw_held_reg, w_held_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic busy_reg, skip_reg;

  // register map decode, shared by read and write paths
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a[11:10] == XMU_MEM_SEL) || a == XMU_CMD_OFS || a == XMU_WORK_OFS ||
      a == XMU_FLAG_OFS || a == XMU_STAT_OFS;
  endfunction

  wire logic aw_hs = s_axi_awvalid_i & awready_reg;
  wire logic w_hs = s_axi_wvalid_i & wready_reg;
  wire logic ar_hs = s_axi_arvalid_i & arready_reg;
  // register writes wait for idle so the datapath owns memory alone
  wire logic do_write = aw_held_reg & w_held_reg & ~bvalid_reg & (state_reg == ST_IDLE);
  wire logic wr_lo = wstrb_reg[0];
  wire logic wr_cmd = do_write & awaddr_reg == XMU_CMD_OFS;
  wire logic launch = wr_cmd & ~skip_arm_reg;
  wire logic [4:0] op = cmd_reg[XMU_OP_LSB +: 5];
  wire logic [2:0] bsel = cmd_reg[XMU_BIT_LSB +: 3];
  wire logic [7:0] adr = cmd_reg[XMU_ADR_LSB +: 8];
  wire logic c_in = flag_reg[XMU_FC];

  // datapath results for the operation in commit
  logic [7:0] res;
  logic to_mem, to_work, do_skip, arith, new_c;
  logic [8:0] diff;
  logic [4:0] hdiff;
  logic bin;
  always_comb begin
    bin = (op == OP_SBC_W || op == OP_SBC_M) ? ~c_in : 1'b0;
    diff = {1'b0, work_reg} - {1'b0, opnd_reg} - {8'h00, bin};
    hdiff = {1'b0, work_reg[3:0]} - {1'b0, opnd_reg[3:0]} - {4'h0, bin};
    res = opnd_reg;
    to_mem = 1'b0;
    to_work = 1'b0;
    do_skip = 1'b0;
    arith = 1'b0;
    new_c = c_in;
    case (op)
      OP_ROT, OP_ROT_W: begin
        res = {opnd_reg[0], opnd_reg[7:1]};
        to_mem = (op == OP_ROT);
        to_work = (op == OP_ROT_W);
      end
      OP_ROTC, OP_ROTC_W: begin
        res = {c_in, opnd_reg[7:1]};
        new_c = opnd_reg[0];
        to_mem = (op == OP_ROTC);
        to_work = (op == OP_ROTC_W);
      end
      OP_SBC_W, OP_SBC_M, OP_SUB_W, OP_SUB_M: begin
        res = diff[7:0];
        arith = 1'b1;
        to_mem = (op == OP_SBC_M || op == OP_SUB_M);
        to_work = ~to_mem;
      end
      OP_DSZ, OP_DSZ_W: begin
        res = opnd_reg - 8'h01;
        to_mem = (op == OP_DSZ);
        to_work = (op == OP_DSZ_W);
        do_skip = (res == 8'h00);
      end
      OP_ISZ, OP_ISZ_W: begin
        res = opnd_reg + 8'h01;
        to_mem = (op == OP_ISZ);
        to_work = (op == OP_ISZ_W);
        do_skip = (res == 8'h00);
      end
      OP_FILL: begin
        res = XMU_ONES;
        to_mem = 1'b1;
      end
      OP_SETB: begin
        res = opnd_reg | (8'h01 << bsel);
        to_mem = 1'b1;
      end
      OP_SZ, OP_SNZ: begin
        to_mem = 1'b1;
        do_skip = (op == OP_SZ) ? (opnd_reg == 8'h00) : (opnd_reg != 8'h00);
      end
      OP_SZ_W: begin
        to_work = 1'b1;
        do_skip = (opnd_reg == 8'h00);
      end
      OP_SZB: do_skip = ~opnd_reg[bsel];
      OP_SNZB: do_skip = opnd_reg[bsel];
      OP_SWAP, OP_SWAP_W: begin
        res = {opnd_reg[3:0], opnd_reg[7:4]};
        to_mem = (op == OP_SWAP);
        to_work = (op == OP_SWAP_W);
      end
      default: res = opnd_reg;
    endcase
  end

  // sequencer: load, commit, optional dummy slot
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: if (launch) state_reg <= ST_LOAD;
        ST_LOAD: state_reg <= ST_COMMIT;
        ST_COMMIT: state_reg <= do_skip ? ST_DUMMY : ST_IDLE;
        ST_DUMMY: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_reg <= 16'h0000;
    end else if (launch) begin
      cmd_reg <= wdata_reg[15:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      opnd_reg <= 8'h00;
    end else if (state_reg == ST_LOAD) begin
      opnd_reg <= mem_reg[adr];
    end
  end

  // the next command after a taken skip is the skipped one
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      skip_arm_reg <= 1'b0;
    end else if (state_reg == ST_COMMIT && do_skip) begin
      skip_arm_reg <= 1'b1;
    end else if (wr_cmd) begin
      skip_arm_reg <= 1'b0;
    end
  end

  // memory has no reset: contents are undefined at power-up
  always_ff @(posedge clk_sys_i) begin
    if (state_reg == ST_COMMIT && to_mem) begin
      mem_reg[adr] <= res;
    end else if (do_write && awaddr_reg[11:10] == XMU_MEM_SEL && wr_lo) begin
      mem_reg[awaddr_reg[9:2]] <= wdata_reg[7:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      work_reg <= XMU_WORK_RST;
    end else if (state_reg == ST_COMMIT && to_work) begin
      work_reg <= res;
    end else if (do_write && awaddr_reg == XMU_WORK_OFS && wr_lo) begin
      work_reg <= wdata_reg[7:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_reg <= XMU_FLAG_RST;
    end else if (state_reg == ST_COMMIT && arith) begin
      flag_reg[XMU_FC] <= ~diff[8];
      flag_reg[XMU_FAC] <= ~hdiff[4];
      flag_reg[XMU_FZ] <= (res == 8'h00);
      flag_reg[XMU_FOV] <= (work_reg[7] ^ opnd_reg[7]) & (work_reg[7] ^ res[7]);
      flag_reg[XMU_FSC] <= ~((work_reg[7] ^ opnd_reg[7]) & (work_reg[7] ^ res[7]) ^ res[7]);
      // chained zero: an incoming borrow needs the earlier zero to carry on
      flag_reg[XMU_FCZ] <= (res == 8'h00) & (~bin | flag_reg[XMU_FCZ]);
    end else if (state_reg == ST_COMMIT) begin
      flag_reg[XMU_FC] <= new_c;
    end else if (do_write && awaddr_reg == XMU_FLAG_OFS && wr_lo) begin
      flag_reg <= wdata_reg[5:0];
    end
  end

  // axi write channels: address and data taken in either order
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_held_reg <= 1'b0;
      awready_reg <= 1'b0;
      awaddr_reg <= 12'h000;
    end else begin
      aw_held_reg <= (aw_held_reg | aw_hs) & ~do_write;
      awready_reg <= ~((aw_held_reg | aw_hs) & ~do_write);
      if (aw_hs) awaddr_reg <= {s_axi_awaddr_i[11:2], 2'b00};
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      w_held_reg <= 1'b0;
      wready_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      w_held_reg <= (w_held_reg | w_hs) & ~do_write;
      wready_reg <= ~((w_held_reg | w_hs) & ~do_write);
      if (w_hs) begin
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= XMU_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= is_mapped(awaddr_reg) ? XMU_OKAY : XMU_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_reg <= 1'b0;
    end
  end

  // axi read: one word answered the cycle after the address is taken
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b0;
      rresp_reg <= XMU_OKAY;
      rdata_reg <= 32'h00000000;
    end else begin
      rvalid_reg <= (rvalid_reg & ~s_axi_rready_i) | ar_hs;
      arready_reg <= ~((rvalid_reg & ~s_axi_rready_i) | ar_hs);
      if (ar_hs) begin
        rresp_reg <= is_mapped({s_axi_araddr_i[11:2], 2'b00}) ? XMU_OKAY : XMU_SLVERR;
        rdata_reg <= 32'h00000000;
        if (s_axi_araddr_i[11:10] == XMU_MEM_SEL) begin
          rdata_reg[7:0] <= mem_reg[s_axi_araddr_i[9:2]];
        end else begin
          case ({s_axi_araddr_i[11:2], 2'b00})
            XMU_CMD_OFS: rdata_reg[15:0] <= cmd_reg;
            XMU_WORK_OFS: rdata_reg[7:0] <= work_reg;
            XMU_FLAG_OFS: rdata_reg[5:0] <= flag_reg;
            XMU_STAT_OFS: rdata_reg[2:0] <= {skip_arm_reg, state_reg == ST_DUMMY,
              state_reg != ST_IDLE};
            default: rdata_reg <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // status pins, registered so they line up with the sequencer state
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_reg <= 1'b0;
      skip_reg <= 1'b0;
    end else begin
      busy_reg <= launch | (state_reg == ST_LOAD) | (state_reg == ST_COMMIT && do_skip);
      skip_reg <= (state_reg == ST_COMMIT) & do_skip;
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign busy_o = busy_reg;
  assign skip_o = skip_reg;

  rot_right_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (state_reg == ST_COMMIT && op == OP_ROT) |=> mem_reg[$past(adr)] ==
      {$past(opnd_reg[0]), $past(opnd_reg[7:1])} && $stable(flag_reg))
    else $error("rotate right result wrong");
  rot_work_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (state_reg == ST_COMMIT && op == OP_ROT_W) |=> work_reg ==
      {$past(opnd_reg[0]), $past(opnd_reg[7:1])} && mem_reg[$past(adr)] == $past(opnd_reg))
    else $error("rotate to work wrong");
  rot_carry_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (state_reg == ST_COMMIT && (op == OP_ROTC || op == OP_ROTC_W)) |=>
      flag_reg[XMU_FC] == $past(opnd_reg[0]) && flag_reg[5:1] == $past(flag_reg[5:1]))
    else $error("carry rotate flags wrong");
  sub_result_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (state_reg == ST_COMMIT && op == OP_SBC_W) |=> work_reg ==
      8'($past(work_reg) - $past(opnd_reg) - {7'h00, ~$past(flag_reg[XMU_FC])}))
    else $error("borrow subtract wrong");
  sub_carry_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (state_reg == ST_COMMIT && op == OP_SUB_M) |=>
      flag_reg[XMU_FC] == ($past(work_reg) >= $past(opnd_reg)))
    else $error("subtract carry wrong");
  inc_skip_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (state_reg == ST_COMMIT && op == OP_ISZ && opnd_reg == 8'hff) |=>
      skip_o && state_reg == ST_DUMMY ##1 state_reg == ST_IDLE)
    else $error("increment skip missing");
  three_cyc_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (state_reg == ST_LOAD) |=> (state_reg == ST_COMMIT) ##1
      (state_reg == ST_DUMMY || state_reg == ST_IDLE))
    else $error("sequence length wrong");
  skip_squash_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (wr_cmd && skip_arm_reg) |=> state_reg == ST_IDLE && $stable(work_reg) &&
      $stable(flag_reg) && !skip_arm_reg)
    else $error("skipped command took effect");
  mem_fill_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (state_reg == ST_COMMIT && op == OP_FILL) |=> mem_reg[$past(adr)] == XMU_ONES)
    else $error("fill wrong");
  nibble_swap_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (state_reg == ST_COMMIT && op == OP_SWAP) |=> mem_reg[$past(adr)] ==
      {$past(opnd_reg[3:0]), $past(opnd_reg[7:4])} && $stable(flag_reg))
    else $error("nibble exchange wrong");
  dec_skip_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (state_reg == ST_COMMIT && op == OP_DSZ) |=> mem_reg[$past(adr)] ==
      8'($past(opnd_reg) - 8'h01) && skip_o == ($past(opnd_reg) == 8'h01))
    else $error("decrement skip wrong");
  byte_rewrite_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (state_reg == ST_COMMIT && (op == OP_SZ || op == OP_SNZ)) |=>
      mem_reg[$past(adr)] == $past(opnd_reg) && $stable(work_reg) && $stable(flag_reg))
    else $error("byte test rewrite wrong");
  copy_skip_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (state_reg == ST_COMMIT && op == OP_SZ_W) |=> work_reg == $past(opnd_reg) &&
      skip_o == ($past(opnd_reg) == 8'h00) && $stable(flag_reg))
    else $error("copy and skip wrong");
  bit_set_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (state_reg == ST_COMMIT && op == OP_SETB) |=> mem_reg[$past(adr)] ==
      ($past(opnd_reg) | (8'h01 << $past(bsel))) && $stable(flag_reg))
    else $error("bit set wrong");
endmodule

// [sim/xmu_axi_master.sv]
// axi4-lite master model standing in for the sequencer side
module xmu_axi_master (
  input wire logic clk_i,
  output logic [11:0] awaddr_o,
  output logic awvalid_o,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic awready_i,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  output logic [11:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_i);
    awaddr_o <= a;
    awvalid_o <= 1'b1;
    wdata_o <= d;
    wstrb_o <= 4'h1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_i);
      if (!aw_ok && awready_i === 1'b1) begin
        aw_ok = 1'b1;
        awvalid_o <= 1'b0;
      end
      if (!w_ok && wready_i === 1'b1) begin
        w_ok = 1'b1;
        wvalid_o <= 1'b0;
      end
    end
    do @(posedge clk_i); while (bvalid_i !== 1'b1);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    do @(posedge clk_i); while (arready_i !== 1'b1);
    arvalid_o <= 1'b0;
    do @(posedge clk_i); while (rvalid_i !== 1'b1);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask
endmodule

// [sim/xmu_exec_unit_tb_top.sv]
// self-checking bench for the memory-operand execute unit
module xmu_exec_unit_tb_top import xmu_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, busy, skip;
  logic busy_q = 1'b0;
  int n_fail = 0;
  int total_checks = 0;
  int n_skip = 0;
  int run_len = 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  xmu_exec_unit DUT (.clk_sys_i(clk), .resetn_i(resetn), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .busy_o(busy), .skip_o(skip));
  xmu_axi_master M (.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .wdata_o(wdata),
    .wstrb_o(wstrb), .wvalid_o(wvalid), .awready_i(awready), .wready_i(wready),
    .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
    .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
    .rvalid_i(rvalid), .rready_o(rready));
  // skip pulses counted and busy run length measured per operation
  always @(posedge clk) begin
    if (skip === 1'b1) n_skip <= n_skip + 1;
    if (busy === 1'b1) run_len <= (busy_q === 1'b1) ? run_len + 1 : 1;
    busy_q <= busy;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [11:0] ma(input logic [7:0] i);
    return 12'h400 | {2'h0, i, 2'h0};
  endfunction
  // status polled until both busy and dummy slot clear
  task automatic idle;
    do M.rd(XMU_STAT_OFS, rv, rs); while (rv[1:0] !== 2'b00);
  endtask
  task automatic op(input logic [4:0] code, input logic [2:0] b, input logic [7:0] adr,
                    input logic sk);
    int s0;
    s0 = n_skip;
    M.wr(XMU_CMD_OFS, {16'h0, adr, b, code}, rs);
    idle();
    chk(n_skip - s0, {31'h0, sk});
    chk(run_len, sk ? 32'h3 : 32'h2);
    if (sk) begin
      // the following command must be swallowed: a fill that never lands
      M.wr(XMU_CMD_OFS, {16'h0, 8'h09, 3'h0, OP_FILL}, rs);
      idle();
      M.rd(ma(8'h09), rv, rs);
      chk(rv, 32'h5a);
    end
  endtask
  function automatic logic [13:0] sub_ref(input logic [7:0] a, input logic [7:0] b,
                                          input logic sbc, input logic [5:0] f);
    logic cin;
    logic [8:0] s;
    logic [4:0] h;
    logic [5:0] fl;
    cin = sbc ? f[XMU_FC] : 1'b1;
    s = {1'b0, a} + {1'b0, ~b} + {8'h0, cin};
    h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
    fl[XMU_FC] = s[8];
    fl[XMU_FAC] = h[4];
    fl[XMU_FZ] = (s[7:0] == 8'h00);
    fl[XMU_FOV] = (a[7] ^ b[7]) & (a[7] ^ s[7]);
    fl[XMU_FSC] = ~(fl[XMU_FOV] ^ s[7]);
    fl[XMU_FCZ] = sbc ? (fl[XMU_FZ] & (f[XMU_FCZ] | cin)) : fl[XMU_FZ];
    return {fl, s[7:0]};
  endfunction
  task automatic t_bus;
    M.rd(XMU_WORK_OFS, rv, rs);
    chk(rv, {24'h0, XMU_WORK_RST});
    M.rd(12'h010, rv, rs);
    chk({30'h0, rs}, {30'h0, XMU_SLVERR});
    M.wr(12'h010, 32'h1, rs);
    chk({30'h0, rs}, {30'h0, XMU_SLVERR});
    M.wr(XMU_STAT_OFS, 32'h7, rs);
    chk({30'h0, rs}, {30'h0, XMU_OKAY});
    M.rd(XMU_STAT_OFS, rv, rs);
    chk(rv, 32'h0);
    $display("test bus done");
  endtask
  // skip, op, bit, initial byte, expected byte, expected work
  logic [43:0] tab [22] = '{44'h0_00_00_81_c0_77, 44'h0_01_00_81_81_c0,
    44'h1_08_00_01_00_77, 44'h0_08_00_05_04_77, 44'h1_09_00_01_01_00,
    44'h1_0a_00_ff_00_77, 44'h0_0b_00_05_05_06, 44'h1_0e_00_00_00_77,
    44'h0_0e_00_05_05_77, 44'h1_0f_00_05_05_77, 44'h0_0f_00_00_00_77,
    44'h1_10_00_00_00_00, 44'h0_10_00_5a_5a_5a, 44'h1_11_03_f7_f7_77,
    44'h0_11_03_08_08_77, 44'h1_12_03_08_08_77, 44'h0_12_00_fe_fe_77,
    44'h0_0c_00_12_ff_77, 44'h0_0d_06_00_40_77, 44'h0_0d_07_7f_ff_77,
    44'h0_13_00_3c_c3_77, 44'h0_14_00_3c_3c_c3};
  task automatic t_flagless;
    logic [43:0] e;
    for (int k = 0; k < 22; k++) begin
      e = tab[k];
      M.wr(XMU_WORK_OFS, 32'h77, rs);
      M.wr(XMU_FLAG_OFS, 32'h2a, rs);
      M.wr(ma(8'h06), {24'h0, e[23:16]}, rs);
      op(e[36:32], e[26:24], 8'h06, e[40]);
      M.rd(ma(8'h06), rv, rs);
      chk(rv, {24'h0, e[15:8]});
      M.rd(XMU_WORK_OFS, rv, rs);
      chk(rv, {24'h0, e[7:0]});
      M.rd(XMU_FLAG_OFS, rv, rs);
      chk(rv, 32'h2a);
    end
    $display("test flagless ops done");
  endtask
  task automatic t_rotc;
    M.wr(XMU_FLAG_OFS, 32'h01, rs);
    M.wr(ma(8'h03), 32'h02, rs);
    op(OP_ROTC, 3'h0, 8'h03, 1'b0);
    M.rd(ma(8'h03), rv, rs);
    chk(rv, 32'h81);
    M.rd(XMU_FLAG_OFS, rv, rs);
    chk(rv, 32'h00);
    M.wr(ma(8'h03), 32'h01, rs);
    op(OP_ROTC_W, 3'h0, 8'h03, 1'b0);
    M.rd(XMU_WORK_OFS, rv, rs);
    chk(rv, 32'h00);
    M.rd(XMU_FLAG_OFS, rv, rs);
    chk(rv, 32'h01);
    M.rd(ma(8'h03), rv, rs);
    chk(rv, 32'h01);
    $display("test carry rotate done");
  endtask
  // op, work, memory operand, flags in
  logic [31:0] st [6] = '{32'h04_10_10_00, 32'h05_80_01_21, 32'h06_05_05_00,
    32'h07_03_08_01, 32'h04_20_1f_20, 32'h05_20_1f_00};
  task automatic t_sub;
    logic [31:0] e;
    logic [13:0] x;
    for (int k = 0; k < 6; k++) begin
      e = st[k];
      M.wr(XMU_WORK_OFS, {24'h0, e[23:16]}, rs);
      M.wr(XMU_FLAG_OFS, {24'h0, e[7:0]}, rs);
      M.wr(ma(8'h05), {24'h0, e[15:8]}, rs);
      op(e[28:24], 3'h0, 8'h05, 1'b0);
      x = sub_ref(e[23:16], e[15:8], ~e[25], e[5:0]);
      M.rd(XMU_WORK_OFS, rv, rs);
      chk(rv, {24'h0, e[24] ? e[23:16] : x[7:0]});
      M.rd(ma(8'h05), rv, rs);
      chk(rv, {24'h0, e[24] ? x[7:0] : e[15:8]});
      M.rd(XMU_FLAG_OFS, rv, rs);
      chk(rv, {26'h0, x[13:8]});
    end
    $display("test subtract done");
  endtask
  initial begin
    #500000;
    n_fail++;
    complete_run;
  end
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    M.wr(ma(8'h09), 32'h5a, rs);
    t_bus;
    t_flagless;
    t_rotc;
    t_sub;
    complete_run;
  end
endmodule
